/* File: include/fqg_defs.svh */
// offsets, table values and widths of the query geometry table
// assumes word addressing: one table byte per word address
`ifndef FQG_DEFS_SVH
`define FQG_DEFS_SVH

`define FQG_ADDR_W 8
`define FQG_HI_BYTE 8'h00
`define FQG_OFF_VCC_MIN 8'h1b
`define FQG_OFF_VCC_MAX 8'h1c
`define FQG_OFF_VPP_MIN 8'h1d
`define FQG_OFF_VPP_MAX 8'h1e
`define FQG_OFF_TYP_WORD 8'h1f
`define FQG_OFF_TYP_BUF 8'h20
`define FQG_OFF_TYP_BLK 8'h21
`define FQG_OFF_TYP_CHIP 8'h22
`define FQG_OFF_MAX_WORD 8'h23
`define FQG_OFF_MAX_BUF 8'h24
`define FQG_OFF_MAX_BLK 8'h25
`define FQG_OFF_MAX_CHIP 8'h26
`define FQG_OFF_SIZE 8'h27
`define FQG_OFF_IFC_LO 8'h28
`define FQG_OFF_IFC_HI 8'h29
`define FQG_OFF_WBUF_LO 8'h2a
`define FQG_OFF_WBUF_HI 8'h2b
`define FQG_OFF_REGIONS 8'h2c
`define FQG_OFF_R1_0 8'h2d
`define FQG_OFF_R1_1 8'h2e
`define FQG_OFF_R1_2 8'h2f
`define FQG_OFF_R1_3 8'h30
`define FQG_OFF_R2_0 8'h31
`define FQG_OFF_R2_1 8'h32
`define FQG_OFF_R2_2 8'h33
`define FQG_OFF_R2_3 8'h34
`define FQG_OFF_RSVD_0 8'h35
`define FQG_OFF_RSVD_3 8'h38

`define FQG_VAL_VCC_MIN 8'h23
`define FQG_VAL_VCC_MAX 8'h36
`define FQG_VAL_VPP_MIN 8'h85
`define FQG_VAL_VPP_MAX 8'h95
`define FQG_VAL_TYP_WORD 8'h09
`define FQG_VAL_TYP_BUF 8'h0a
`define FQG_VAL_TYP_BLK 8'h0a
`define FQG_VAL_NONE 8'h00
`define FQG_VAL_MAX_WORD 8'h01
`define FQG_VAL_MAX_BUF 8'h02
`define FQG_VAL_MAX_BLK 8'h02
`define FQG_VAL_SIZE_512M 8'h1a
`define FQG_VAL_SIZE_BIG 8'h1b
`define FQG_VAL_IFC_LO 8'h01
`define FQG_VAL_WBUF_LO 8'h0a
`define FQG_VAL_REG_ASYM 8'h02
`define FQG_VAL_REG_SYM 8'h01
`define FQG_VAL_CNT_TOP 8'hfe
`define FQG_VAL_CNT_BOT 8'h03
`define FQG_VAL_CNT_SYM 8'hff
`define FQG_VAL_CNT_HI_512M 8'h01
`define FQG_VAL_CNT_HI_BIG 8'h03
`define FQG_VAL_SZ_LO_PARAM 8'h80
`define FQG_VAL_SZ_HI_MAIN 8'h02

`endif

/* File: include/fqg_pkg.sv */
// types shared by the query geometry table
// assumes fqg_defs.svh supplies the address width
`include "fqg_defs.svh"

package fqg_pkg;

	typedef enum logic [1:0]
	{
		FQG_DEN_512M = 2'h0,
		FQG_DEN_1G = 2'h1,
		FQG_DEN_2G = 2'h2
	} fqg_density_t;

	typedef enum logic [1:0]
	{
		FQG_PL_TOP = 2'h0,
		FQG_PL_BOTTOM = 2'h1,
		FQG_PL_SYM = 2'h2
	} fqg_place_t;

	// every pin input, carried through the synchroniser as one word
	typedef struct packed
	{
		logic query_mode;
		logic read_n;
		fqg_density_t density;
		fqg_place_t place;
		logic [`FQG_ADDR_W-1:0] addr;
	} fqg_pins_t;

endpackage

/* File: tb/fqg_host_model.sv */
// host side model: drives query mode, read strobe, straps and word address
// assumes the table answers within five edges of steady pins
`include "fqg_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module fqg_host_model
(
	input wire logic clock_in, // system clock
	input wire logic [15:0] dq_in, // data pins from the device
	input wire logic dq_oe_n_in, // low while the device drives data
	output logic query_mode_out, // query mode request
	output logic read_n_out, // read strobe, low reads
	output logic [1:0] density_out, // density strap
	output logic [1:0] place_out, // placement strap
	output logic [`FQG_ADDR_W-1:0] addr_out // word address
);

	////////////////////////////////////////////////////////////////////////
	// idle pins until the first access
	initial
	begin
		query_mode_out = 1'b0;
		read_n_out = 1'b1;
		density_out = 2'h0;
		place_out = 2'h0;
		addr_out = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// one access: pins held for six edges, more than the synchroniser needs
	task automatic access(input logic qm, input logic rn, input logic [1:0] den,
		input logic [1:0] pl, input logic [7:0] off, output logic [15:0] data,
		output logic oe_n);
		@(posedge clock_in);
		#1;
		query_mode_out = qm;
		read_n_out = rn;
		density_out = den;
		place_out = pl;
		addr_out = off;
		repeat (6) @(posedge clock_in);
		#1;
		data = dq_in;
		oe_n = dq_oe_n_in;
	endtask

endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the query geometry table
// assumes the host model holds pins long enough for each answer
`include "fqg_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;

	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic query_mode;
	logic read_n;
	logic [1:0] density;
	logic [1:0] place;
	logic [7:0] addr;
	logic [15:0] dq;
	logic dq_oe_n;
	logic [15:0] got;
	logic oe;
	int n_fail = 0;
	int cmp_count = 0;
	logic [1:0] den_tab [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2};
	logic [1:0] pl_tab [7] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2};

	////////////////////////////////////////////////////////////////////////
	// clock, design and host
	always #5 clock_in = ~clock_in;

	fqg_query_rom u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.query_mode_in(query_mode), .read_n_in(read_n), .density_in(density),
		.place_in(place), .addr_in(addr), .dq_out(dq), .dq_oe_n_out(dq_oe_n));

	fqg_host_model u_host (.clock_in(clock_in), .dq_in(dq), .dq_oe_n_in(dq_oe_n),
		.query_mode_out(query_mode), .read_n_out(read_n), .density_out(density),
		.place_out(place), .addr_out(addr));

	////////////////////////////////////////////////////////////////////////
	// expected table byte per column, worked out independently of the design
	function automatic logic [7:0] exp_byte(input logic [1:0] d, input logic [1:0] p,
		input logic [7:0] o);
		logic [7:0] big;
		logic bot;
		big = (d == 2'h0) ? 8'h01 : 8'h03;
		bot = (p == 2'h1);
		case (o)
			8'h1b: return 8'h23;
			8'h1c: return 8'h36;
			8'h1d: return 8'h85;
			8'h1e: return 8'h95;
			8'h1f: return 8'h09;
			8'h20, 8'h21, 8'h2a: return 8'h0a;
			8'h23, 8'h28: return 8'h01;
			8'h24, 8'h25: return 8'h02;
			8'h27: return (d == 2'h0) ? 8'h1a : 8'h1b;
			8'h2c: return (p == 2'h2) ? 8'h01 : 8'h02;
			8'h2d: return (p == 2'h0) ? 8'hfe : (bot ? 8'h03 : 8'hff);
			8'h2e: return bot ? 8'h00 : big;
			8'h2f: return bot ? 8'h80 : 8'h00;
			8'h30: return bot ? 8'h00 : 8'h02;
			8'h31: return (p == 2'h0) ? 8'h03 : (bot ? 8'hfe : 8'h00);
			8'h32: return bot ? big : 8'h00;
			8'h33: return (p == 2'h0) ? 8'h80 : 8'h00;
			8'h34: return bot ? 8'h02 : 8'h00;
			default: return 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// comparison and verdict
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_oe(input logic g, input logic e);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
		begin
			$display("[ PASS ]");
		end
		else
		begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog: the whole walk takes about 16 us
	initial
	begin
		#200000;
		n_fail++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence: every column, every offset including both edges
	initial
	begin
		repeat (12) @(posedge clock_in);
		#1;
		sys_rst_in = 1'b0;
		@(posedge clock_in);
		#1;
		chk(dq, 16'h0000);
		chk_oe(dq_oe_n, 1'b1);
		for (int c = 0; c < 7; c++)
		begin
			for (int o = 8'h1a; o <= 8'h39; o++)
			begin
				u_host.access(1'b1, 1'b0, den_tab[c], pl_tab[c], o[7:0], got, oe);
				chk(got, {8'h00, exp_byte(den_tab[c], pl_tab[c], o[7:0])});
				chk_oe(oe, 1'b0);
			end
		end
		// strobe released, then query mode left: pins must go quiet
		u_host.access(1'b1, 1'b1, 2'h0, 2'h0, 8'h1b, got, oe);
		chk(got, 16'h0000);
		chk_oe(oe, 1'b1);
		u_host.access(1'b0, 1'b0, 2'h0, 2'h0, 8'h1b, got, oe);
		chk(got, 16'h0000);
		chk_oe(oe, 1'b1);
		// reset in mid-read: pins quiet on the next edge, the read returns after the synchroniser
		u_host.access(1'b1, 1'b0, 2'h0, 2'h0, 8'h1b, got, oe);
		chk(got, 16'h0023);
		sys_rst_in = 1'b1;
		@(posedge clock_in);
		#1;
		chk(dq, 16'h0000);
		chk_oe(dq_oe_n, 1'b1);
		sys_rst_in = 1'b0;
		repeat (6) @(posedge clock_in);
		#1;
		chk(dq, 16'h0023);
		chk_oe(dq_oe_n, 1'b0);
		close_out();
	end

endmodule
`default_nettype wire

/* File: verilog/fqg_query_rom.sv */
// query geometry table of a parallel flash: word address in, byte on dq
// assumes a host that holds address and read strobe steady while reading
//
// What this block does
// - query byte low, upper data byte zero
// - offsets are word addresses on address pins
// - offset 1Bh returns 23h
// - offset 1Ch returns 36h
// - offset 1Dh returns 85h
// - offset 1Eh returns 95h
// - offset 1Fh returns 09h
// - offset 20h returns 0Ah
// - offset 21h returns 0Ah
// - offsets 22h and 26h return zero
// - offset 23h returns 01h
// - offset 24h returns 02h
// - offset 25h returns 02h
// - interface code 01h then 00h
// - write buffer exponent 0Ah then 00h
// - region count two asymmetric, one symmetric
// - descriptor: count minus one, size/256
// - offsets 35h to 38h read zero
`include "fqg_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module fqg_query_rom
(
	input wire logic clock_in, // 100 MHz system clock
	input wire logic sys_rst_in, // synchronous reset, active high
	input wire logic query_mode_in, // device is in query mode
	input wire logic read_n_in, // output enable from host, low reads
	input wire logic [1:0] density_in, // density strap
	input wire logic [1:0] place_in, // parameter block placement strap
	input wire logic [`FQG_ADDR_W-1:0] addr_in, // word address pins
	output logic [15:0] dq_out, // data pins, output value
	output logic dq_oe_n_out // low while data pins are driven
);

	////////////////////////////////////////////////////////////////////
	// pin synchroniser: three stages, accept once stages two and three agree

	fqg_pkg::fqg_pins_t pins_now;
	fqg_pkg::fqg_pins_t sync_1;
	fqg_pkg::fqg_pins_t sync_2;
	fqg_pkg::fqg_pins_t sync_3;
	fqg_pkg::fqg_pins_t taken;

	// the enums take the raw strap codes; illegal codes are handled below
	always_comb
	begin
		pins_now.query_mode = query_mode_in;
		pins_now.read_n = read_n_in;
		pins_now.density = fqg_pkg::fqg_density_t'(density_in);
		pins_now.place = fqg_pkg::fqg_place_t'(place_in);
		pins_now.addr = addr_in;
	end

	// stage one is read only by stage two
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			sync_1 <= '0;
			sync_2 <= '0;
			sync_3 <= '0;
		end
		else
		begin
			sync_1 <= pins_now;
			sync_2 <= sync_1;
			sync_3 <= sync_2;
		end
	end

	// a skewed address bus reaches the table only if a mixed word holds for two samples: a word seen in one sample only is not taken
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			taken.query_mode <= 1'b0;
			taken.read_n <= 1'b1;
			taken.density <= fqg_pkg::FQG_DEN_512M;
			taken.place <= fqg_pkg::FQG_PL_TOP;
			taken.addr <= '0;
		end
		else if (sync_2 == sync_3)
		begin
			taken <= sync_3;
		end
	end

	////////////////////////////////////////////////////////////////////
	// column select from the straps

	logic is_top;
	logic is_bottom;
	logic is_small;

	// 2Gb parts have only the symmetric column; odd codes fall to symmetric
	always_comb
	begin
		is_small = (taken.density == fqg_pkg::FQG_DEN_512M);
		is_top = (taken.place == fqg_pkg::FQG_PL_TOP)
			&& (taken.density != fqg_pkg::FQG_DEN_2G)
			&& (taken.density != fqg_pkg::fqg_density_t'(2'h3));
		is_bottom = (taken.place == fqg_pkg::FQG_PL_BOTTOM)
			&& (taken.density != fqg_pkg::FQG_DEN_2G)
			&& (taken.density != fqg_pkg::fqg_density_t'(2'h3));
	end

	////////////////////////////////////////////////////////////////////
	// table lookup

	logic [7:0] next_byte;
	logic [7:0] cnt_hi;

	// upper block count byte of a region depends on density only
	always_comb
	begin
		cnt_hi = is_small ? `FQG_VAL_CNT_HI_512M : `FQG_VAL_CNT_HI_BIG;
	end

	// descriptors: count minus one low word, size/256 high word, lsb first
	always_comb
	begin
		next_byte = `FQG_VAL_NONE;
		case (taken.addr)
			`FQG_OFF_VCC_MIN: next_byte = `FQG_VAL_VCC_MIN;
			`FQG_OFF_VCC_MAX: next_byte = `FQG_VAL_VCC_MAX;
			`FQG_OFF_VPP_MIN: next_byte = `FQG_VAL_VPP_MIN;
			`FQG_OFF_VPP_MAX: next_byte = `FQG_VAL_VPP_MAX;
			`FQG_OFF_TYP_WORD: next_byte = `FQG_VAL_TYP_WORD;
			`FQG_OFF_TYP_BUF: next_byte = `FQG_VAL_TYP_BUF;
			`FQG_OFF_TYP_BLK: next_byte = `FQG_VAL_TYP_BLK;
			`FQG_OFF_TYP_CHIP: next_byte = `FQG_VAL_NONE;
			`FQG_OFF_MAX_WORD: next_byte = `FQG_VAL_MAX_WORD;
			`FQG_OFF_MAX_BUF: next_byte = `FQG_VAL_MAX_BUF;
			`FQG_OFF_MAX_BLK: next_byte = `FQG_VAL_MAX_BLK;
			`FQG_OFF_MAX_CHIP: next_byte = `FQG_VAL_NONE;
			`FQG_OFF_SIZE:
				next_byte = is_small ? `FQG_VAL_SIZE_512M : `FQG_VAL_SIZE_BIG;
			`FQG_OFF_IFC_LO: next_byte = `FQG_VAL_IFC_LO;
			`FQG_OFF_IFC_HI: next_byte = `FQG_VAL_NONE;
			`FQG_OFF_WBUF_LO: next_byte = `FQG_VAL_WBUF_LO;
			`FQG_OFF_WBUF_HI: next_byte = `FQG_VAL_NONE;
			`FQG_OFF_REGIONS:
				next_byte = (is_top || is_bottom) ? `FQG_VAL_REG_ASYM
					: `FQG_VAL_REG_SYM;
			`FQG_OFF_R1_0:
				next_byte = is_top ? `FQG_VAL_CNT_TOP
					: (is_bottom ? `FQG_VAL_CNT_BOT : `FQG_VAL_CNT_SYM);
			`FQG_OFF_R1_1: next_byte = is_bottom ? `FQG_VAL_NONE : cnt_hi;
			`FQG_OFF_R1_2: next_byte = is_bottom ? `FQG_VAL_SZ_LO_PARAM : `FQG_VAL_NONE;
			`FQG_OFF_R1_3: next_byte = is_bottom ? `FQG_VAL_NONE : `FQG_VAL_SZ_HI_MAIN;
			`FQG_OFF_R2_0:
				next_byte = is_top ? `FQG_VAL_CNT_BOT
					: (is_bottom ? `FQG_VAL_CNT_TOP : `FQG_VAL_NONE);
			`FQG_OFF_R2_1: next_byte = is_bottom ? cnt_hi : `FQG_VAL_NONE;
			`FQG_OFF_R2_2: next_byte = is_top ? `FQG_VAL_SZ_LO_PARAM : `FQG_VAL_NONE;
			`FQG_OFF_R2_3: next_byte = is_bottom ? `FQG_VAL_SZ_HI_MAIN : `FQG_VAL_NONE;
			default: next_byte = `FQG_VAL_NONE; // reserved 35h-38h too
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// data pins: registered so the host sees no decode glitches

	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			dq_out <= 16'h0000;
			dq_oe_n_out <= 1'b1;
		end
		else if (taken.query_mode && !taken.read_n)
		begin
			dq_out <= {`FQG_HI_BYTE, next_byte};
			dq_oe_n_out <= 1'b0;
		end
		else
		begin
			dq_out <= 16'h0000;
			dq_oe_n_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (sys_rst_in);

	logic rd;
	assign rd = taken.query_mode && !taken.read_n;

	// columns worked out again from the straps, apart from the lookup's flags
	logic chk_top;
	logic chk_bot;
	assign chk_top = (taken.place == fqg_pkg::FQG_PL_TOP)
		&& (taken.density inside {fqg_pkg::FQG_DEN_512M, fqg_pkg::FQG_DEN_1G});
	assign chk_bot = (taken.place == fqg_pkg::FQG_PL_BOTTOM)
		&& (taken.density inside {fqg_pkg::FQG_DEN_512M, fqg_pkg::FQG_DEN_1G});

	sequence s_rd(logic [7:0] a);
		rd && taken.addr == a;
	endsequence

	property p_upper_zero;
		!dq_oe_n_out |-> dq_out[15:8] == 8'h00;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper data byte not zero");

	property p_stable_take;
		(sync_2 == sync_3) |=> taken == $past(sync_3);
	endproperty
	a_stable_take: assert property (p_stable_take)
		else $error("agreed pins not taken");

	property p_vcc;
		s_rd(8'h1b) |=> dq_out == 16'h0023 ##0 !dq_oe_n_out;
	endproperty
	a_vcc: assert property (p_vcc)
		else $error("1Bh wrong");

	property p_vcc_max;
		s_rd(8'h1c) |=> dq_out == 16'h0036;
	endproperty
	a_vcc_max: assert property (p_vcc_max)
		else $error("1Ch wrong");

	property p_vpp;
		s_rd(8'h1d) |=> dq_out == 16'h0085;
	endproperty
	a_vpp: assert property (p_vpp)
		else $error("1Dh wrong");

	property p_vpp_max;
		s_rd(8'h1e) |=> dq_out == 16'h0095;
	endproperty
	a_vpp_max: assert property (p_vpp_max)
		else $error("1Eh wrong");

	property p_typ_word;
		s_rd(8'h1f) |=> dq_out == 16'h0009;
	endproperty
	a_typ_word: assert property (p_typ_word)
		else $error("1Fh wrong");

	property p_typ_buf_blk;
		(s_rd(8'h20) or s_rd(8'h21)) |=> dq_out == 16'h000a;
	endproperty
	a_typ_buf_blk: assert property (p_typ_buf_blk)
		else $error("20h or 21h wrong");

	property p_chip_none;
		(s_rd(8'h22) or s_rd(8'h26)) |=> dq_out == 16'h0000 && !dq_oe_n_out;
	endproperty
	a_chip_none: assert property (p_chip_none)
		else $error("chip erase entry not zero");

	property p_max_mult;
		s_rd(8'h23) |=> dq_out == 16'h0001;
	endproperty
	a_max_mult: assert property (p_max_mult)
		else $error("23h wrong");

	property p_max_buf;
		s_rd(8'h24) |=> dq_out == 16'h0002;
	endproperty
	a_max_buf: assert property (p_max_buf)
		else $error("24h wrong");

	property p_max_blk;
		s_rd(8'h25) |=> dq_out == 16'h0002;
	endproperty
	a_max_blk: assert property (p_max_blk)
		else $error("25h wrong");

	property p_ifc;
		s_rd(8'h28) |=> dq_out == 16'h0001;
	endproperty
	a_ifc: assert property (p_ifc)
		else $error("interface code wrong");

	property p_wbuf;
		s_rd(8'h2a) |=> dq_out == 16'h000a;
	endproperty
	a_wbuf: assert property (p_wbuf)
		else $error("write buffer exponent wrong");

	property p_size;
		s_rd(8'h27) |=> dq_out[7:0]
			== (($past(taken.density) == fqg_pkg::FQG_DEN_512M) ? 8'h1a : 8'h1b);
	endproperty
	a_size: assert property (p_size)
		else $error("size exponent wrong");

	property p_regions;
		s_rd(8'h2c) |=> dq_out[7:0] == ($past(chk_top || chk_bot) ? 8'h02 : 8'h01);
	endproperty
	a_regions: assert property (p_regions)
		else $error("region count wrong");

	property p_region_one;
		s_rd(8'h2d) |=> dq_out[7:0]
			== ($past(chk_top) ? 8'hfe : ($past(chk_bot) ? 8'h03 : 8'hff));
	endproperty
	a_region_one: assert property (p_region_one)
		else $error("first region count wrong");

	property p_region_size;
		s_rd(8'h2f) |=> dq_out[7:0] == ($past(chk_bot) ? 8'h80 : 8'h00);
	endproperty
	a_region_size: assert property (p_region_size)
		else $error("first region size wrong");

	property p_region_two;
		s_rd(8'h31) |=> dq_out[7:0]
			== ($past(chk_top) ? 8'h03 : ($past(chk_bot) ? 8'hfe : 8'h00));
	endproperty
	a_region_two: assert property (p_region_two)
		else $error("second region count wrong");

	property p_desc_size;
		s_rd(8'h34) |=> dq_out[7:0] == ($past(chk_bot) ? 8'h02 : 8'h00);
	endproperty
	a_desc_size: assert property (p_desc_size)
		else $error("second region size wrong");

	property p_bot_cnt;
		(rd && taken.addr == 8'h32 && chk_bot) |=> dq_out[7:0]
			== (($past(taken.density) == fqg_pkg::FQG_DEN_512M) ? 8'h01 : 8'h03);
	endproperty
	a_bot_cnt: assert property (p_bot_cnt)
		else $error("bottom main count wrong");

	property p_reserved;
		(rd && taken.addr >= 8'h35 && taken.addr <= 8'h38) |=> dq_out == 16'h0000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved entry not zero");

	property p_idle;
		!rd |=> dq_oe_n_out;
	endproperty
	a_idle: assert property (p_idle)
		else $error("driving outside a query read");

	// main scenarios: a first read, then each placement column
	c_vcc: cover property (s_rd(8'h1b) ##1 !dq_oe_n_out);
	c_bottom: cover property (rd && taken.addr == 8'h2f && chk_bot);
	c_top: cover property (rd && taken.addr == 8'h31 && chk_top);
	c_sym: cover property (rd && taken.addr == 8'h2d && !chk_top && !chk_bot);

endmodule

`default_nettype wire
